// ==== rtl/wutc_core.sv ====
// Functional notes
// - Control bit 7 reads back whether the timer is counting.
// - A write changes the running bit only when permit bit 6 is set in the same write.
// - Auto-trim set: every underflow launches an oscillator trim run.
// - Auto card detect set: every underflow starts a detection sequence.
// - Card found: interrupt raised, chip stays active if enabled.
// - No card found: return to power down if enabled.
// - During card detection the countdown restarts with no gap.
// - Detection sequence uses timer three for the field-on time.
// - Auto-restart set: reload from reload word at zero, keep counting.
// - Auto-restart and auto card detect both clear: count down to zero and halt.
// - Every underflow sets the wake-up timer interrupt flag.
// - Auto-wake set: wake the system at every underflow.
// - Tick select: 00 undivided, 01 by 8, 10 by 16, 11 by 32.
// - Reload word is copied to the counter at a start event and at each underflow that keeps counting.
// - Current count readable as high and low bytes.
`timescale 1ns/100ps
`default_nettype none
module wutc_core
  import wutc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lfo_tick,
  input  wire logic        card_seq_done,
  input  wire logic        card_found,
  output logic             trim_start,
  output logic             card_seq_start,
  output logic             timer3_field_req,
  output logic             system_wake,
  output logic             power_down_req,
  output logic             irq
);

  typedef enum logic [1:0] {WUTC_SEQ_IDLE, WUTC_SEQ_BUSY} wutc_seq_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic        running_r;
  logic [5:0]  ctrl_r;
  logic [15:0] reload_r;
  logic [15:0] count_r;
  logic [4:0]  prescale_r;
  logic [1:0]  status_r;
  logic [1:0]  mask_r;
  logic [1:0]  seq_ctrl_r;
  wutc_seq_t   seq_r;
  logic        trim_start_r;
  logic        card_start_r;
  logic        wake_r;
  logic        pd_r;
  logic [31:0] prdata_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        acc       = psel & penable;
  wire        wr        = acc & pwrite;
  wire [9:0]  word_idx  = paddr[11:2];
  wire        hit_ctrl  = word_idx == {2'h0, WUTC_IDX_CONTROL};
  wire        hit_rhi   = word_idx == {2'h0, WUTC_IDX_RELOAD_HIGH};
  wire        hit_rlo   = word_idx == {2'h0, WUTC_IDX_RELOAD_LOW};
  wire        hit_chi   = word_idx == {2'h0, WUTC_IDX_COUNT_HIGH};
  wire        hit_clo   = word_idx == {2'h0, WUTC_IDX_COUNT_LOW};
  wire        hit_sts   = word_idx == {2'h0, WUTC_IDX_IRQ_STATUS};
  wire        hit_msk   = word_idx == {2'h0, WUTC_IDX_IRQ_MASK};
  wire        hit_seq   = word_idx == {2'h0, WUTC_IDX_SEQ_CTRL};
  wire        hit_any   = hit_ctrl | hit_rhi | hit_rlo | hit_chi | hit_clo
                          | hit_sts | hit_msk | hit_seq;
  wire        wr_ctrl   = wr & hit_ctrl;
  wire        permit    = pwdata[WUTC_BIT_PERMIT];
  wire        run_set   = wr_ctrl & permit & pwdata[WUTC_BIT_RUNNING];
  wire        run_clr   = wr_ctrl & permit & ~pwdata[WUTC_BIT_RUNNING];

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  function automatic logic [4:0] div_mask(input logic [1:0] sel);
    case (sel)
      WUTC_TICK_DIV1:  div_mask = 5'h00;
      WUTC_TICK_DIV8:  div_mask = 5'h07;
      WUTC_TICK_DIV16: div_mask = 5'h0F;
      WUTC_TICK_DIV32: div_mask = 5'h1F;
      default:         div_mask = 5'h00;
    endcase
  endfunction

  wire [1:0] tick_source_select = ctrl_r[WUTC_TICK_LSB +: 2];
  wire [4:0] pmask = div_mask(tick_source_select);
  // Prescaler wraps at the selected mask; one count tick per wrap
  wire       count_tick = running_r & lfo_tick
                          & ((prescale_r & pmask) == pmask);
  wire       underflow  = count_tick & (count_r == 16'h0000);

  wire auto_osc_trim      = ctrl_r[WUTC_BIT_AUTO_TRIM];
  wire auto_card_detect   = ctrl_r[WUTC_BIT_AUTO_CARD];
  wire auto_reload_repeat = ctrl_r[WUTC_BIT_REPEAT];
  wire auto_system_wake   = ctrl_r[WUTC_BIT_WAKE];
  // Card detection keeps the timer going regardless of the repeat bit
  wire keep_counting      = auto_reload_repeat | auto_card_detect;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescale_r <= 5'h00;
    end else if (run_set || !running_r) begin
      prescale_r <= 5'h00;
    end else if (lfo_tick) begin
      prescale_r <= (prescale_r & pmask) == pmask ? 5'h00 : prescale_r + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Counter and run state
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      running_r <= WUTC_RST_CONTROL[WUTC_BIT_RUNNING];
      count_r   <= WUTC_RST_RELOAD;
    end else if (run_set) begin
      running_r <= 1'b1;
      count_r   <= reload_r;
    end else if (run_clr) begin
      running_r <= 1'b0;
    end else if (underflow) begin
      running_r <= keep_counting;
      count_r   <= keep_counting ? reload_r : count_r;
    end else if (count_tick) begin
      count_r <= count_r - 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r     <= WUTC_RST_CONTROL[5:0];
      reload_r   <= WUTC_RST_RELOAD;
      mask_r     <= WUTC_RST_MASK;
      seq_ctrl_r <= WUTC_RST_SEQ;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {pwdata[WUTC_BIT_AUTO_TRIM:WUTC_BIT_WAKE], pwdata[1:0]};
      end
      if (wr & hit_rhi) begin
        reload_r[15:8] <= pwdata[7:0];
      end
      if (wr & hit_rlo) begin
        reload_r[7:0] <= pwdata[7:0];
      end
      if (wr & hit_msk) begin
        mask_r <= pwdata[1:0];
      end
      if (wr & hit_seq) begin
        seq_ctrl_r <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Underflow actions and detection sequence
  // ----------------------------------------------------------------
  wire card_done   = (seq_r == WUTC_SEQ_BUSY) & card_seq_done;
  wire card_hit    = card_done & card_found;
  wire card_miss   = card_done & ~card_found;
  wire [1:0] sts_set = {card_hit, underflow};
  wire [1:0] sts_clr = (wr & hit_sts) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seq_r        <= WUTC_SEQ_IDLE;
      trim_start_r <= 1'b0;
      card_start_r <= 1'b0;
      wake_r       <= 1'b0;
      pd_r         <= 1'b0;
      status_r     <= 2'h0;
    end else begin
      trim_start_r <= underflow & auto_osc_trim;
      card_start_r <= underflow & auto_card_detect;
      // Set beats a simultaneous write-one clear
      status_r     <= (status_r & ~sts_clr) | sts_set;
      if (underflow && auto_system_wake) begin
        wake_r <= 1'b1;
        pd_r   <= 1'b0;
      end else if (card_hit && seq_ctrl_r[WUTC_SEQ_CARD_KEEP]) begin
        wake_r <= 1'b1;
        pd_r   <= 1'b0;
      end else if (card_miss && seq_ctrl_r[WUTC_SEQ_PD_RETURN]) begin
        wake_r <= 1'b0;
        pd_r   <= 1'b1;
      end else begin
        pd_r <= 1'b0;
      end
      case (seq_r)
        WUTC_SEQ_IDLE: begin
          if (underflow && auto_card_detect) begin
            seq_r <= WUTC_SEQ_BUSY;
          end
        end
        WUTC_SEQ_BUSY: begin
          if (card_seq_done) begin
            seq_r <= WUTC_SEQ_IDLE;
          end
        end
        default: seq_r <= WUTC_SEQ_IDLE;
      endcase
    end
  end

  assign trim_start       = trim_start_r;
  assign card_seq_start   = card_start_r;
  // Field-on window timed by timer three while the sequence runs
  assign timer3_field_req = seq_r == WUTC_SEQ_BUSY;
  assign system_wake      = wake_r;
  assign power_down_req   = pd_r;
  assign irq              = |(status_r & mask_r);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] ctrl_rd = {running_r, 1'b0, ctrl_r};
  wire [7:0] rd_mux  = hit_ctrl ? ctrl_rd :
                       hit_rhi  ? reload_r[15:8] :
                       hit_rlo  ? reload_r[7:0] :
                       hit_chi  ? count_r[15:8] :
                       hit_clo  ? count_r[7:0] :
                       hit_sts  ? {6'h00, status_r} :
                       hit_msk  ? {6'h00, mask_r} :
                       hit_seq  ? {6'h00, seq_ctrl_r} : 8'h00;

  // Setup-cycle capture keeps read data registered; access answers at once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= {24'h00_0000, rd_mux};
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_permit_gate;
    @(posedge clock) disable iff (!nrst)
      (wr_ctrl && !permit && !underflow) |=> running_r == $past(running_r);
  endproperty
  a_permit_gate: assert property (p_permit_gate)
    else $error("running changed without permit");

  property p_start_load;
    @(posedge clock) disable iff (!nrst)
      run_set |=> running_r && count_r == $past(reload_r);
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("start did not load reload word");

  property p_halt;
    @(posedge clock) disable iff (!nrst)
      (underflow && !keep_counting && !wr_ctrl) |=> !running_r;
  endproperty
  a_halt: assert property (p_halt)
    else $error("timer did not halt");

  property p_reload;
    @(posedge clock) disable iff (!nrst)
      (underflow && keep_counting && !wr_ctrl) |=> running_r && count_r == $past(reload_r);
  endproperty
  a_reload: assert property (p_reload)
    else $error("timer did not reload");

  property p_flag;
    @(posedge clock) disable iff (!nrst)
      underflow |=> status_r[WUTC_IRQ_UNDERFLOW];
  endproperty
  a_flag: assert property (p_flag)
    else $error("underflow flag not set");

  property p_trim;
    @(posedge clock) disable iff (!nrst)
      (underflow && auto_osc_trim) |=> trim_start ##1 !trim_start;
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim pulse missing");

  property p_card;
    @(posedge clock) disable iff (!nrst)
      (underflow && auto_card_detect && !card_done) |=> card_seq_start && timer3_field_req;
  endproperty
  a_card: assert property (p_card)
    else $error("detection not started");

  property p_wake;
    @(posedge clock) disable iff (!nrst)
      (underflow && auto_system_wake) |=> system_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on underflow");

  property p_miss;
    @(posedge clock) disable iff (!nrst)
      (card_miss && seq_ctrl_r[WUTC_SEQ_PD_RETURN] && !(underflow && auto_system_wake))
        |=> power_down_req ##1 !power_down_req;
  endproperty
  a_miss: assert property (p_miss)
    else $error("no power-down after empty detection");

  property p_decrement;
    @(posedge clock) disable iff (!nrst)
      (count_tick && !underflow && !wr_ctrl) |=> count_r == $past(count_r) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("count did not decrement");

  property p_card_keep;
    @(posedge clock) disable iff (!nrst)
      (card_hit && seq_ctrl_r[WUTC_SEQ_CARD_KEEP]) |=> system_wake && status_r[WUTC_IRQ_CARD];
  endproperty
  a_card_keep: assert property (p_card_keep)
    else $error("card found but not kept awake");

  property p_field_end;
    @(posedge clock) disable iff (!nrst)
      card_done |=> !timer3_field_req;
  endproperty
  a_field_end: assert property (p_field_end)
    else $error("field request outlived the sequence");

  property p_count_read;
    @(posedge clock) disable iff (!nrst)
      (psel && !penable && !pwrite && hit_clo) |=> prdata[7:0] == $past(count_r[7:0]);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count low byte read mismatch");

endmodule
`default_nettype wire

// ==== rtl/wutc_pkg.sv ====
`default_nettype none
package wutc_pkg;

  // ----------------------------------------------------------------
  // Register indices (printed offsets, byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] WUTC_IDX_CONTROL     = 8'h23;
  localparam logic [7:0] WUTC_IDX_RELOAD_HIGH = 8'h24;
  localparam logic [7:0] WUTC_IDX_RELOAD_LOW  = 8'h25;
  localparam logic [7:0] WUTC_IDX_COUNT_HIGH  = 8'h26;
  localparam logic [7:0] WUTC_IDX_COUNT_LOW   = 8'h27;
  localparam logic [7:0] WUTC_IDX_IRQ_STATUS  = 8'h30;
  localparam logic [7:0] WUTC_IDX_IRQ_MASK    = 8'h31;
  localparam logic [7:0] WUTC_IDX_SEQ_CTRL    = 8'h32;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int WUTC_BIT_RUNNING   = 7;
  localparam int WUTC_BIT_PERMIT    = 6;
  localparam int WUTC_BIT_AUTO_TRIM = 5;
  localparam int WUTC_BIT_AUTO_CARD = 4;
  localparam int WUTC_BIT_REPEAT    = 3;
  localparam int WUTC_BIT_WAKE      = 2;
  localparam int WUTC_TICK_LSB      = 0;

  // Tick divide codes
  localparam logic [1:0] WUTC_TICK_DIV1  = 2'h0;
  localparam logic [1:0] WUTC_TICK_DIV8  = 2'h1;
  localparam logic [1:0] WUTC_TICK_DIV16 = 2'h2;
  localparam logic [1:0] WUTC_TICK_DIV32 = 2'h3;

  // Interrupt status bits
  localparam int WUTC_IRQ_UNDERFLOW = 0;
  localparam int WUTC_IRQ_CARD      = 1;

  // Sequence control bits
  localparam int WUTC_SEQ_CARD_KEEP = 0;
  localparam int WUTC_SEQ_PD_RETURN = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  WUTC_RST_CONTROL = 8'h00;
  localparam logic [15:0] WUTC_RST_RELOAD  = 16'h0000;
  localparam logic [1:0]  WUTC_RST_MASK    = 2'h0;
  localparam logic [1:0]  WUTC_RST_SEQ     = 2'h3;

endpackage
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wutc_pkg::*;
  logic clock, nrst, psel, penable, pwrite, lfo_tick, card_seq_done, card_found;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, trim_start, card_seq_start, timer3_field_req, system_wake;
  logic power_down_req, irq, err;
  logic [15:0] rld, cnt;
  int errors, tests_run, cyc, n_trim, n_card, n_pd;
  int divs [4] = '{1, 8, 16, 32};

  wutc_core dut_u (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lfo_tick(lfo_tick), .card_seq_done(card_seq_done),
    .card_found(card_found), .trim_start(trim_start), .card_seq_start(card_seq_start),
    .timer3_field_req(timer3_field_req), .system_wake(system_wake),
    .power_down_req(power_down_req), .irq(irq));

  // ----------------------------------------------------------------
  // Clock, pulse monitors, hang guard
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (trim_start === 1'b1) n_trim++;
    if (card_seq_start === 1'b1) n_card++;
    if (power_down_req === 1'b1) n_pd++;
    if (cyc == 60000) begin
      errors++;
      $display("ERROR t=%0t timeout cyc=%h limit=%h", $time, cyc, 60000);
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; leaves one idle edge so the next call never re-drives psel
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic rdcnt(input logic [15:0] exp);
    apb(1'b0, WUTC_IDX_COUNT_HIGH, 32'h0);
    cnt[15:8] = rdat[7:0];
    apb(1'b0, WUTC_IDX_COUNT_LOW, 32'h0);
    cnt[7:0] = rdat[7:0];
    chk({16'h0, cnt}, {16'h0, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      lfo_tick <= 1'b1;
      @(posedge clock);
      lfo_tick <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask

  task automatic card_end(input logic found);
    card_seq_done <= 1'b1;
    card_found <= found;
    @(posedge clock);
    card_seq_done <= 1'b0;
    card_found <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic set_reload(input logic [15:0] v);
    apb(1'b1, WUTC_IDX_RELOAD_HIGH, {24'h0, v[15:8]});
    apb(1'b1, WUTC_IDX_RELOAD_LOW, {24'h0, v[7:0]});
  endtask

  function automatic logic [31:0] ctl(input logic run, input logic pm, input logic tr,
    input logic cd, input logic rp, input logic wk, input logic [1:0] tk);
    ctl = {24'h0, run, pm, tr, cd, rp, wk, tk};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, psel, penable, pwrite, lfo_tick, card_seq_done, card_found} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(32'h08617A06));
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(WUTC_IDX_CONTROL, 32'h0);
    rd(WUTC_IDX_RELOAD_HIGH, 32'h0);
    rd(WUTC_IDX_IRQ_MASK, 32'h0);
    rd(WUTC_IDX_SEQ_CTRL, {30'h0, WUTC_RST_SEQ});
    rdcnt(16'h0000);
    chk({31'h0, irq}, 32'h0);
    rd(8'h28, 32'h0);
    chk({31'h0, err}, 32'h1);
    rld = 16'($urandom);
    set_reload(rld);
    rd(WUTC_IDX_RELOAD_HIGH, {24'h0, rld[15:8]});
    rd(WUTC_IDX_RELOAD_LOW, {24'h0, rld[7:0]});
    chk({31'h0, err}, 32'h0);
    // Run bit refused without permit; permit bit itself reads back as zero
    apb(1'b1, WUTC_IDX_CONTROL, ctl(1, 0, 0, 0, 0, 0, 2'h1));
    rd(WUTC_IDX_CONTROL, ctl(0, 0, 0, 0, 0, 0, 2'h1));
    // One-shot countdown
    rld = 16'($urandom_range(6, 2));
    set_reload(rld);
    apb(1'b1, WUTC_IDX_CONTROL, ctl(1, 1, 0, 0, 0, 0, WUTC_TICK_DIV1));
    rdcnt(rld);
    tick(1);
    rdcnt(rld - 16'h1);
    tick(int'(rld) - 1);
    rd(WUTC_IDX_CONTROL, ctl(1, 0, 0, 0, 0, 0, WUTC_TICK_DIV1));
    tick(1);
    rd(WUTC_IDX_CONTROL, ctl(0, 0, 0, 0, 0, 0, WUTC_TICK_DIV1));
    rd(WUTC_IDX_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, WUTC_IDX_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, WUTC_IDX_IRQ_STATUS, 32'h1);
    rd(WUTC_IDX_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Every tick divide code, checked at the edge of its prescaler period
    for (int k = 0; k < 4; k++) begin
      rld = 16'($urandom_range(16'hFFFF, 16'h0010));
      set_reload(rld);
      apb(1'b1, WUTC_IDX_CONTROL, ctl(1, 1, 0, 0, 0, 0, 2'(k)));
      tick(divs[k] - 1);
      rdcnt(rld);
      tick(1);
      rdcnt(rld - 16'h1);
      apb(1'b1, WUTC_IDX_CONTROL, ctl(0, 1, 0, 0, 0, 0, 2'(k)));
      rd(WUTC_IDX_CONTROL, ctl(0, 0, 0, 0, 0, 0, 2'(k)));
    end
    // Auto restart with trim and wake
    rld = 16'h0001;
    set_reload(rld);
    // Trim partner timers taken as configured; auto-wake set so each underflow wakes the system
    apb(1'b1, WUTC_IDX_CONTROL, ctl(1, 1, 1, 0, 1, 1, WUTC_TICK_DIV1));
    tick(2);
    chk(n_trim, 1);
    chk({31'h0, system_wake}, 32'h1);
    rd(WUTC_IDX_IRQ_STATUS, 32'h1);
    rdcnt(rld);
    rd(WUTC_IDX_CONTROL, ctl(1, 0, 1, 0, 1, 1, WUTC_TICK_DIV1));
    set_reload(16'h00F0);
    rdcnt(rld);
    apb(1'b1, WUTC_IDX_CONTROL, ctl(0, 1, 0, 0, 0, 0, WUTC_TICK_DIV1));
    apb(1'b1, WUTC_IDX_IRQ_STATUS, 32'h3);
    // Card detection: no card, then card found
    set_reload(rld);
    apb(1'b1, WUTC_IDX_IRQ_MASK, 32'h2);
    apb(1'b1, WUTC_IDX_CONTROL, ctl(1, 1, 0, 1, 0, 0, WUTC_TICK_DIV1));
    tick(2);
    chk(n_card, 1);
    chk({31'h0, timer3_field_req}, 32'h1);
    rdcnt(rld);
    rd(WUTC_IDX_CONTROL, ctl(1, 0, 0, 1, 0, 0, WUTC_TICK_DIV1));
    card_end(1'b0);
    chk(n_pd, 1);
    chk({31'h0, system_wake}, 32'h0);
    chk({31'h0, timer3_field_req}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    tick(2);
    chk(n_card, 2);
    card_end(1'b1);
    chk(n_pd, 1);
    chk({31'h0, irq}, 32'h1);
    rd(WUTC_IDX_IRQ_STATUS, 32'h3);
    // Both sequence options off: empty run neither sleeps nor drops wake
    apb(1'b1, WUTC_IDX_SEQ_CTRL, 32'h0);
    rd(WUTC_IDX_SEQ_CTRL, 32'h0);
    tick(2);
    chk(n_card, 3);
    card_end(1'b0);
    chk(n_pd, 1);
    chk({31'h0, system_wake}, 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
